// File: verilog/scuim_pkg.sv
`default_nettype none
package scuim_pkg;
    // Divider field sits in bits 15..9 of the channel data high byte
    localparam int DIV_MSB = 15;
    localparam int DIV_LSB = 9;
    localparam int DIV_W = DIV_MSB - DIV_LSB + 1;
    // Frame layout
    localparam int START_BITS = 1;
    localparam int DATA_BITS = 8;
    localparam int ACK_BIT = 8; // Index of the extra ack bit period
    // Receive buffer
    localparam int FIFO_DEPTH = 8;
    // Channel numbering
    localparam int CHANNEL_COUNT = 2;
    localparam int TWO_WIRE_CHANNEL = 0;
    // Positions in the flag clear trigger
    localparam int CLR_W = 3;
    localparam int CLR_OVF = 0;
    localparam int CLR_PEF = 1;
    localparam int CLR_FEF = 2;
    // Channel sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_URX = 3'h2,
        ST_IIC = 3'h4
    } scuim_state_t;
endpackage
`default_nettype wire

// File: verilog/scuim_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module scuim_fifo #(
    parameter int WIDTH = 8, // Word width
    parameter int DEPTH = 8 // Words in the array
) (
    input wire logic clk, // Clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    input wire logic [WIDTH-1:0] in_data, // Word in
    output logic out_valid, // Head word waiting
    input wire logic out_ready, // Head word taken
    output logic [WIDTH-1:0] out_data // Head word, registered
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
        $error("scuim_fifo needs DEPTH of 2 or more");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [WIDTH-1:0] od;
    } scuim_fifo_regs_t;

    scuim_fifo_regs_t f_reg;
    scuim_fifo_regs_t f_next;
    logic push;
    logic load;

    ////////////////////////////////////////////////////////////////////////
    // Array plus an output register so read data come from a flop
    assign in_ready = (f_reg.cnt != (AW+1)'(DEPTH));
    assign out_valid = f_reg.ov;
    assign out_data = f_reg.od;
    assign push = in_valid && in_ready;
    assign load = (f_reg.cnt != '0) && (!f_reg.ov || out_ready);

    always_comb begin
        f_next = f_reg;
        if (out_ready && f_reg.ov) begin
            f_next.ov = 1'b0;
        end
        if (load) begin
            f_next.od = f_reg.mem[f_reg.rp];
            f_next.ov = 1'b1;
            f_next.rp = (f_reg.rp == AW'(DEPTH - 1)) ? '0 : f_reg.rp + 1'b1;
        end
        if (push) begin
            f_next.mem[f_reg.wp] = in_data;
            f_next.wp = (f_reg.wp == AW'(DEPTH - 1)) ? '0 : f_reg.wp + 1'b1;
        end
        f_next.cnt = f_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            f_reg <= '0;
        end else begin
            f_reg <= f_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Taking the last word drops the full flag at once
    a_read_clears_full: assert property (@(posedge clk) disable iff (!rst_b)
        out_valid && out_ready && f_reg.cnt == '0 && !in_valid |=> !out_valid)
        else $error("head flag stayed after last word read");
    a_no_overfill: assert property (@(posedge clk) disable iff (!rst_b)
        f_reg.cnt <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule
`default_nettype wire

// File: verilog/scuim_top.sv
`timescale 1ns/10ps
`default_nettype none
module scuim_top
    import scuim_pkg::*;
#(
    parameter int CHANNEL = 0, // Channel number within the unit
    parameter int FIFO_WORDS = FIFO_DEPTH // Receive buffer depth
) (
    input wire logic clk, // 50 MHz operation clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic mode_two_wire, // 1: two-wire master, 0: async rx
    input wire logic [DIV_W-1:0] baud_divider_field, // Divider value
    input wire logic parity_en, // Async frame carries parity
    input wire logic parity_odd, // Odd parity when set
    input wire logic two_stop, // Async frame has two stop bits
    input wire logic channel_start_bit, // Start pulse
    input wire logic channel_stop_bit, // Stop pulse
    input wire logic clear_write, // Strobe for the clear trigger
    input wire logic [CLR_W-1:0] flag_clear_trigger, // Ones clear flags
    input wire logic data_read, // Strobe: received byte read
    input wire logic rx_pin, // Async serial input pin
    input wire logic tx_start, // Starts one two-wire frame
    input wire logic tx_receive, // Frame receives a byte
    input wire logic [DATA_BITS-1:0] tx_data, // Byte to send
    input wire logic data_output_enable_bit, // Data output enable
    input wire logic sw_clock_level, // Clock level outside frames
    input wire logic sw_data_level, // Data level outside frames
    input wire logic two_wire_data_pin_in, // Data pin level
    output logic channel_enabled_flag, // Channel running
    output logic rx_buffer_full_flag, // Received byte waiting
    output logic [DATA_BITS-1:0] rx_data, // Oldest received byte
    output logic parity_ack_error_flag, // Parity or missing ack
    output logic overrun_flag, // Byte lost to a full buffer
    output logic framing_flag, // Stop bit seen low
    output logic channel_busy, // Frame in progress
    output logic two_wire_transfer_end_irq, // One pulse per frame
    output logic two_wire_clock_pin_out, // Clock pin level when driven
    output logic two_wire_clock_pin_oe, // Clock pin pulled low
    output logic two_wire_data_pin_out, // Data pin level when driven
    output logic two_wire_data_pin_oe // Data pin pulled low
);
    localparam bit TW_OK = (CHANNEL == TWO_WIRE_CHANNEL);

    if (CHANNEL < 0 || CHANNEL >= CHANNEL_COUNT || FIFO_WORDS < 2) begin
        : g_bad_cfg
        $error("scuim_top channel or buffer depth out of range");
    end

    typedef struct packed {
        scuim_state_t st;
        logic en;
        logic [1:0] rx_sync;
        logic [1:0] sda_sync;
        logic rx_prev;
        logic [DIV_W-1:0] cnt;
        logic half;
        logic [3:0] bitn;
        logic [DATA_BITS-1:0] sh;
        logic par;
        logic rx_dir;
        logic pin_lvl;
        logic scl_oe;
        logic sda_oe;
        logic irq;
        logic pef;
        logic ovf;
        logic fef;
        logic push;
        logic busy;
    } scuim_regs_t;

    localparam scuim_regs_t S_RESET = '{st: ST_IDLE, default: '0};

    scuim_regs_t s_reg;
    scuim_regs_t s_next;
    logic fifo_ready;
    logic tick;
    logic rxb;
    logic sdab;
    logic start_acc;
    logic stop_smp;
    logic tx_msb;
    logic [3:0] frame_len;
    logic [3:0] first_stop;

    ////////////////////////////////////////////////////////////////////////
    // Frame shape and shared timing terms
    assign frame_len = 4'(START_BITS + DATA_BITS) + {3'h0, parity_en}
        + {3'h0, two_stop} + 4'h1;
    assign first_stop = 4'(START_BITS + DATA_BITS) + {3'h0, parity_en};
    assign tick = (s_reg.cnt == '0);
    assign rxb = s_reg.rx_sync[1];
    assign sdab = s_reg.sda_sync[1];
    assign tx_msb = tx_data[DATA_BITS-1];
    // Master only: a frame starts solely on our own request
    assign start_acc = (s_reg.st == ST_IDLE) && s_reg.en && mode_two_wire
        && TW_OK && tx_start && !channel_stop_bit;
    assign stop_smp = (s_reg.st == ST_URX) && tick && !s_reg.half
        && (s_reg.bitn >= first_stop);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        s_next = s_reg;
        s_next.irq = 1'b0;
        s_next.push = 1'b0;
        s_next.pin_lvl = 1'b0;
        // Pins pass two flops before anything reads them
        s_next.rx_sync = {s_reg.rx_sync[0], rx_pin};
        s_next.sda_sync = {s_reg.sda_sync[0], two_wire_data_pin_in};
        s_next.rx_prev = rxb;
        // Clears first so that a same-cycle set below wins
        if (clear_write) begin
            if (flag_clear_trigger[CLR_OVF]) s_next.ovf = 1'b0;
            if (flag_clear_trigger[CLR_PEF]) s_next.pef = 1'b0;
            if (flag_clear_trigger[CLR_FEF]) s_next.fef = 1'b0;
        end
        // Half-bit timer: divider plus one cycles per half
        if (s_reg.st != ST_IDLE) begin
            s_next.cnt = tick ? baud_divider_field : s_reg.cnt - 1'b1;
        end
        unique case (s_reg.st)
            ST_IDLE: begin
                if (mode_two_wire && TW_OK) begin
                    // Software shapes start and stop
                    s_next.scl_oe = !sw_clock_level;
                    s_next.sda_oe = !sw_data_level && data_output_enable_bit;
                end else begin
                    s_next.scl_oe = 1'b0;
                    s_next.sda_oe = 1'b0;
                end
                if (start_acc) begin
                    s_next.st = ST_IIC;
                    s_next.cnt = baud_divider_field;
                    s_next.half = 1'b0;
                    s_next.bitn = '0;
                    s_next.sh = tx_data;
                    s_next.rx_dir = tx_receive;
                    s_next.scl_oe = 1'b1;
                end else if (s_reg.en && !mode_two_wire && s_reg.rx_prev
                    && !rxb) begin
                    // Falling edge: first latch is half a bit away
                    s_next.st = ST_URX;
                    s_next.cnt = baud_divider_field;
                    s_next.half = 1'b0;
                    s_next.bitn = '0;
                    s_next.par = 1'b0;
                end
            end
            ST_URX: begin
                if (tick) begin
                    s_next.half = !s_reg.half;
                end
                // Latch point every two halves
                if (tick && !s_reg.half) begin
                    s_next.bitn = s_reg.bitn + 1'b1;
                    if (s_reg.bitn == '0) begin
                        if (rxb) begin
                            s_next.st = ST_IDLE; // Glitch, not a start
                        end
                    end else if (s_reg.bitn <= 4'(DATA_BITS)) begin
                        s_next.sh = {rxb, s_reg.sh[DATA_BITS-1:1]};
                        s_next.par = s_reg.par ^ rxb;
                    end else if (s_reg.bitn < first_stop) begin
                        if ((s_reg.par ^ rxb) != parity_odd) begin
                            s_next.pef = 1'b1;
                        end
                    end else begin
                        // Stop high at its latch point is a good frame
                        if (!rxb) begin
                            s_next.fef = 1'b1;
                        end
                        if (s_reg.bitn == frame_len - 4'h1) begin
                            s_next.st = ST_IDLE;
                            s_next.push = fifo_ready;
                            s_next.ovf = s_next.ovf || !fifo_ready;
                        end
                    end
                end
            end
            ST_IIC: begin
                // Drive low only for a zero bit or our own ack
                if (s_reg.bitn == 4'(ACK_BIT)) begin
                    s_next.sda_oe = s_reg.rx_dir && data_output_enable_bit;
                end else begin
                    s_next.sda_oe = !s_reg.rx_dir && !s_reg.sh[DATA_BITS-1]
                        && data_output_enable_bit;
                end
                if (tick) begin
                    s_next.half = !s_reg.half;
                    // Clock is released blind; no stretch wait
                    s_next.scl_oe = s_reg.half;
                    if (s_reg.half) begin
                        if (s_reg.bitn != 4'(ACK_BIT)) begin
                            s_next.sh = {s_reg.sh[DATA_BITS-2:0],
                                s_reg.rx_dir && sdab};
                            s_next.bitn = s_reg.bitn + 1'b1;
                        end else begin
                            // Ack period over: end the frame
                            if (!s_reg.rx_dir && sdab) begin
                                s_next.pef = 1'b1;
                            end
                            if (s_reg.rx_dir) begin
                                s_next.push = fifo_ready;
                                s_next.ovf = s_next.ovf || !fifo_ready;
                            end
                            s_next.irq = 1'b1;
                            s_next.st = ST_IDLE;
                            s_next.scl_oe = !sw_clock_level;
                        end
                    end
                end
            end
        endcase
        // Start then stop so that stop wins a tie
        if (channel_start_bit) begin
            s_next.en = 1'b1;
        end
        if (channel_stop_bit) begin
            s_next.en = 1'b0;
            s_next.st = ST_IDLE;
        end
        s_next.busy = (s_next.st != ST_IDLE);
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_reg <= S_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer; the read strobe pops it
    scuim_fifo #(
        .WIDTH(DATA_BITS),
        .DEPTH(FIFO_WORDS)
    ) u_rx_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(s_reg.push),
        .in_ready(fifo_ready),
        .in_data(s_reg.sh),
        .out_valid(rx_buffer_full_flag),
        .out_ready(data_read),
        .out_data(rx_data)
    );

    // Outputs straight from the state flops
    assign channel_enabled_flag = s_reg.en;
    assign parity_ack_error_flag = s_reg.pef;
    assign overrun_flag = s_reg.ovf;
    assign framing_flag = s_reg.fef;
    assign channel_busy = s_reg.busy;
    assign two_wire_transfer_end_irq = s_reg.irq;
    assign two_wire_clock_pin_out = s_reg.pin_lvl;
    assign two_wire_clock_pin_oe = s_reg.scl_oe;
    assign two_wire_data_pin_out = s_reg.pin_lvl;
    assign two_wire_data_pin_oe = s_reg.sda_oe;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_stop_halts: assert property (@(posedge clk) disable iff (!rst_b)
        channel_stop_bit |=> !channel_enabled_flag && !channel_busy)
        else $error("stop pulse did not halt channel");
    a_start_enables: assert property (@(posedge clk) disable iff (!rst_b)
        channel_start_bit && !channel_stop_bit |=> channel_enabled_flag)
        else $error("start pulse did not enable channel");
    a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        parity_ack_error_flag && !(clear_write && flag_clear_trigger[CLR_PEF])
        |=> parity_ack_error_flag)
        else $error("ack error flag dropped without clear");
    a_flag_clears: assert property (@(posedge clk) disable iff (!rst_b)
        clear_write && flag_clear_trigger[CLR_FEF] && !stop_smp
        |=> !framing_flag)
        else $error("framing flag not cleared");
    a_stop_frame: assert property (@(posedge clk) disable iff (!rst_b)
        stop_smp && !rxb |=> framing_flag)
        else $error("low stop bit not flagged");
    a_div_reload: assert property (@(posedge clk) disable iff (!rst_b)
        s_reg.st == ST_URX && tick && !channel_stop_bit
        |=> s_reg.cnt == $past(baud_divider_field))
        else $error("bit timer not reloaded from divider");
    a_msb_first: assert property (@(posedge clk) disable iff (!rst_b)
        start_acc && !tx_receive ##1 !channel_stop_bit
        |=> two_wire_data_pin_oe == (!$past(tx_msb, 2)
            && $past(data_output_enable_bit)))
        else $error("first data bit is not the byte MSB");
    a_nack_flags: assert property (@(posedge clk) disable iff (!rst_b)
        s_reg.st == ST_IIC && !s_reg.rx_dir && s_reg.bitn == 4'(ACK_BIT)
        && s_reg.half && tick && sdab |=> parity_ack_error_flag)
        else $error("missing ack not flagged");
    a_no_ack_drive: assert property (@(posedge clk) disable iff (!rst_b)
        s_reg.st == ST_IIC && s_reg.rx_dir && s_reg.bitn == 4'(ACK_BIT)
        && !data_output_enable_bit |=> !two_wire_data_pin_oe)
        else $error("ack driven with output disabled");
    a_end_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        two_wire_transfer_end_irq |-> $past(s_reg.st == ST_IIC)
        && $past(s_reg.bitn == 4'(ACK_BIT)) ##1 !two_wire_transfer_end_irq)
        else $error("transfer end not a single pulse after ack");
    a_clock_paced: assert property (@(posedge clk) disable iff (!rst_b)
        $past(s_reg.st == ST_IIC) && s_reg.st == ST_IIC
        && $changed(two_wire_clock_pin_oe) |-> $past(tick))
        else $error("clock edge off the divider pace");
endmodule
`default_nettype wire

// File: test/scuim_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
// Behavioural two-wire slave: shifts in one byte, acks it on request
module scuim_slave_model (
    input wire logic scl, // Clock wire level
    input wire logic sda, // Data wire level
    input wire logic ack_en, // Answer the byte with an ack
    output logic sda_pull, // Pull the data wire low
    output logic [7:0] got // Byte seen on the wire
);
    int n;
    initial begin
        n = 0;
        sda_pull = 1'b0;
        got = 8'h00;
    end
    // Data falling while clock high marks a software start
    always @(negedge sda) begin
        if (scl) n = 0;
    end
    // Sample on rising clock, first bit is the most significant
    always @(posedge scl) begin
        if (n < 8) got = {got[6:0], sda};
        n = n + 1;
    end
    // Hold the ack through the ninth bit only, then let the pull-up win
    always @(negedge scl) begin
        sda_pull = ack_en && (n == 8);
        if (n > 8) n = 0; // Ack done, the next byte follows
    end
endmodule
`default_nettype wire

// File: test/test_serial_channel_uart_iic_master.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_serial_channel_uart_iic_master;
    import scuim_pkg::*;
    localparam int UD = 2; // Async divider, lowest legal value
    localparam int TD = 1; // Two-wire divider, fastest legal value
    localparam int BIT = 2 * (UD + 1);
    logic clk = 0, rst_b = 0, mode = 0, par_en = 0, par_odd = 0, two_stop = 0;
    logic start_b = 0, stop_b = 0, clr_w = 0, rd = 0, rx = 1, tx_go = 0;
    logic tx_rcv = 0, oe_en = 1, sw_scl = 1, sw_sda = 1, ack_en = 1, busy;
    logic [DIV_W-1:0] div = UD[DIV_W-1:0];
    logic [CLR_W-1:0] clr = '0;
    logic [7:0] txd = 8'h00, rxd, got, b, exp;
    logic en_f, full_f, pa_f, ov_f, fr_f, irq, sclo, sdao, scl_oe, sda_oe, pull;
    wire logic scl = scl_oe ? 1'b0 : 1'b1;
    wire logic sda = (sda_oe | pull) ? 1'b0 : 1'b1;
    logic [15:0] seed = 16'hc508;
    logic [7:0] exp_q[$];
    int errors = 0, comparisons = 0, cycles = 0;
    scuim_top DUT (.clk(clk), .rst_b(rst_b), .mode_two_wire(mode),
        .baud_divider_field(div), .parity_en(par_en), .parity_odd(par_odd),
        .two_stop(two_stop), .channel_start_bit(start_b),
        .channel_stop_bit(stop_b), .clear_write(clr_w),
        .flag_clear_trigger(clr), .data_read(rd), .rx_pin(rx),
        .tx_start(tx_go), .tx_receive(tx_rcv), .tx_data(txd),
        .data_output_enable_bit(oe_en), .sw_clock_level(sw_scl),
        .sw_data_level(sw_sda), .two_wire_data_pin_in(sda),
        .channel_enabled_flag(en_f), .rx_buffer_full_flag(full_f),
        .rx_data(rxd), .parity_ack_error_flag(pa_f), .overrun_flag(ov_f),
        .framing_flag(fr_f), .channel_busy(busy),
        .two_wire_transfer_end_irq(irq),
        .two_wire_clock_pin_out(sclo), .two_wire_clock_pin_oe(scl_oe),
        .two_wire_data_pin_out(sdao), .two_wire_data_pin_oe(sda_oe));
    scuim_slave_model slave (.scl(scl), .sda(sda), .ack_en(ack_en),
        .sda_pull(pull), .got(got));
    ////////////////////////////////////////////////////////////////////////
    always #10 clk = ~clk;
    // Hang guard; the whole run needs about 1300 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end
    // Each read strobe with a byte waiting takes the oldest noted byte off the queue
    always @(posedge clk) begin
        if (rd && full_f) begin
            exp = exp_q.pop_front();
            `CHK(rxd, exp)
        end
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 9);
        seed = seed ^ (seed << 8);
        return seed[7:0];
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic clear(input logic [CLR_W-1:0] v);
        clr_w <= 1'b1;
        clr <= v;
        tick(1);
        clr_w <= 1'b0;
        tick(1);
    endtask
    task automatic read_byte();
        rd <= 1'b1;
        tick(1);
        rd <= 1'b0;
        tick(2);
    endtask
    task automatic run_ctl(input logic go);
        start_b <= go;
        stop_b <= !go;
        tick(1);
        start_b <= 1'b0;
        stop_b <= 1'b0;
        tick(1);
        `CHK(en_f, go)
    endtask
    // Frame at exactly the receiver rate, LSB first
    task automatic usend(input logic [7:0] d, input logic p, input logic s);
        logic [10:0] f;
        f = {s, p, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            if (i != 9 || par_en) begin
                rx <= f[i];
                tick(BIT);
            end
        end
        rx <= 1'b1;
        tick(2 * BIT);
    endtask
    task automatic iic_frame(input logic [7:0] a, input logic ack,
        input logic rcv);
        int n;
        ack_en <= ack;
        txd <= a;
        tx_rcv <= rcv;
        tx_go <= 1'b1;
        tick(1);
        tx_go <= 1'b0;
        n = 1;
        // The wait ends on the transfer end pulse; busy is checked on its third cycle
        while (!irq && n < 1000) begin
            tick(1);
            n++;
            if (n == 3) `CHK(busy, 1'b1)
        end
        `CHK(n, 2 + 18 * (TD + 1))
        `CHK(busy, 1'b0)
        `CHK(got, a)
        `CHK(pa_f, !ack && !rcv)
        tick(2);
    endtask
    task automatic print_verdict();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        tick(8);
        rst_b <= 1'b1;
        tick(3);
        run_ctl(1'b1);
        // Nine bytes fill array and output stage, the tenth is lost
        for (int k = 0; k < 10; k++) begin
            b = rnd();
            if (k < 9) exp_q.push_back(b);
            usend(b, 1'b0, 1'b1);
        end
        `CHK(ov_f, 1'b1)
        for (int k = 0; k < 12 && full_f; k++) read_byte();
        `CHK(full_f, 1'b0)
        `CHK(exp_q.size(), 0)
        clear(3'h6);
        `CHK(ov_f, 1'b1)
        clear(3'h1);
        `CHK(ov_f, 1'b0)
        // Wrong even parity: flagged, byte kept, stop still found
        par_en <= 1'b1;
        b = rnd();
        exp_q.push_back(b);
        usend(b, !(^b), 1'b1);
        `CHK({pa_f, fr_f, full_f}, 3'b101)
        read_byte();
        // Good odd parity with two stop bits
        clear(3'h2);
        par_odd <= 1'b1;
        two_stop <= 1'b1;
        b = rnd();
        exp_q.push_back(b);
        usend(b, !(^b), 1'b1);
        `CHK({pa_f, fr_f, full_f}, 3'b001)
        read_byte();
        // Low stop bit, then the recovery sequence
        par_en <= 1'b0;
        two_stop <= 1'b0;
        b = rnd();
        exp_q.push_back(b);
        usend(b, 1'b0, 1'b0);
        `CHK(fr_f, 1'b1)
        read_byte();
        clear(3'h7);
        `CHK({pa_f, fr_f}, 2'b00)
        run_ctl(1'b0);
        usend(rnd(), 1'b0, 1'b1);
        `CHK(full_f, 1'b0)
        run_ctl(1'b1);
        b = rnd();
        exp_q.push_back(b);
        usend(b, 1'b0, 1'b1);
        read_byte();
        // Two-wire address frames, pin already open drain
        mode <= 1'b1;
        div <= TD[DIV_W-1:0];
        tick(2);
        sw_sda <= 1'b0;
        tick(4);
        iic_frame({rnd()}, 1'b1, 1'b0);
        iic_frame({rnd()}, 1'b0, 1'b0);
        // Undriven byte reads as ones; output off means no ack
        clear(3'h2);
        oe_en <= 1'b0;
        exp_q.push_back(8'hff);
        iic_frame(8'hff, 1'b0, 1'b1);
        read_byte();
        sw_scl <= 1'b1;
        sw_sda <= 1'b1;
        tick(4);
        `CHK({scl, sda}, 2'b11)
        `CHK({sclo, sdao}, 2'b00)
        print_verdict();
    end
endmodule
`default_nettype wire
